// >>> pkg/amtoc_pkg.sv
`default_nettype none
package amtoc_pkg;
  localparam int DATA_W = 12;
  localparam int REG_W = 16;
  localparam int ADDR_W = 8;
  localparam int NCH = 2;
  localparam logic [7:0] ADDR_CFG1 = 8'h01;
  localparam logic [7:0] ADDR_CORR_A = 8'h03;
  localparam logic [7:0] ADDR_CORR_B = 8'h1A;
  localparam logic [7:0] ADDR_SLEEP = 8'h37;
  localparam logic [7:0] ADDR_OVR_THR = 8'h38;
  localparam logic [7:0] ADDR_TP_CTRL_A = 8'h3C;
  localparam logic [7:0] ADDR_TP_WORD = 8'h3D;
  localparam logic [7:0] ADDR_TP_CTRL_B = 8'h3E;
  localparam int CFG1_CORR_EN_A = 15;
  localparam int CFG1_CORR_EN_B = 9;
  localparam int CFG1_HIGH_PERF_ONE = 1;
  localparam int CORR_RESTART = 14;
  localparam int CORR_DC_EN = 13;
  localparam int SLEEP_BUSY = 15;
  localparam logic [15:0] CFG1_RST = 16'h0002;
  localparam logic [15:0] CORR_RST = 16'h0000;
  localparam logic [1:0] SLEEP_RST = 2'h0;
  localparam logic [3:0] OVR_THR_RST = 4'hF;
  localparam logic [15:0] TP_RST = 16'h0000;
  localparam logic [15:0] TP_ZERO_A = 16'h8000;
  localparam logic [15:0] TP_ZERO_W = 16'h0000;
  localparam logic [15:0] TP_ZERO_B = 16'h0000;
  localparam logic [15:0] TP_ONES_A = 16'hBFFC;
  localparam logic [15:0] TP_ONES_W = 16'h3FFC;
  localparam logic [15:0] TP_ONES_B = 16'h3FFC;
  localparam logic [15:0] TP_TAA_A = 16'h9554;
  localparam logic [15:0] TP_TAA_W = 16'h2AA8;
  localparam logic [15:0] TP_TAA_B = 16'h1554;
  localparam logic [15:0] TP_TFF_A = 16'hBFFC;
  localparam logic [15:0] TP_TFF_W = 16'h0000;
  localparam logic [15:0] TP_TFF_B = 16'h3FFC;
  localparam logic [11:0] PAT_AAA = 12'hAAA;
  localparam logic [11:0] PAT_555 = 12'h555;
  localparam logic [11:0] PAT_FFF = 12'hFFF;
  localparam logic [11:0] PAT_000 = 12'h000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_SHUTDOWN_NS = 2_500_000;
  localparam int WAKE_STANDBY_NS = 100_000;
  localparam int WAKE_DEEP_NS = 20_000;
  localparam int WAKE_LIGHT_NS = 2_000;
  localparam int WAKE_SHUTDOWN_CYC = (WAKE_SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_STANDBY_CYC = (WAKE_STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_DEEP_CYC = (WAKE_DEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_LIGHT_CYC = (WAKE_LIGHT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVR_LATENCY = 12;
  localparam int OVR_THR_SHIFT = 7;
  typedef enum logic [1:0] {
    SLP_SHUTDOWN = 2'h0,
    SLP_STANDBY = 2'h1,
    SLP_DEEP = 2'h2,
    SLP_LIGHT = 2'h3
  } amtoc_sleep_e;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_WAKE = 2'b11
  } amtoc_pwr_e;
  typedef enum logic [2:0] {
    TP_OFF = 3'h0,
    TP_ZEROS = 3'h1,
    TP_ONES = 3'h2,
    TP_TOG_AA = 3'h3,
    TP_TOG_FF = 3'h4,
    TP_CUSTOM = 3'h5
  } amtoc_tp_e;
endpackage
`default_nettype wire

// >>> src/amtoc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module amtoc_ctrl #(
  parameter int WAKE_SHUTDOWN = amtoc_pkg::WAKE_SHUTDOWN_CYC
) (
  input wire logic clock, // 25 MHz sampling-side clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic enable_pin, // Low requests sleep
  input wire logic reg_wr_en, // Register write strobe
  input wire logic reg_rd_en, // Register read strobe
  input wire logic [amtoc_pkg::ADDR_W-1:0] reg_addr, // Register address
  input wire logic [amtoc_pkg::REG_W-1:0] reg_wdata, // Register write data
  input wire logic [amtoc_pkg::DATA_W-1:0] sub_even_a, // Channel A even sub-converter
  input wire logic [amtoc_pkg::DATA_W-1:0] sub_odd_a, // Channel A odd sub-converter
  input wire logic [amtoc_pkg::DATA_W-1:0] sub_even_b, // Channel B even sub-converter
  input wire logic [amtoc_pkg::DATA_W-1:0] sub_odd_b, // Channel B odd sub-converter
  output logic [amtoc_pkg::REG_W-1:0] reg_rdata, // Read data, one cycle after strobe
  output logic [amtoc_pkg::DATA_W-1:0] data_a, // Channel A output word
  output logic [amtoc_pkg::DATA_W-1:0] data_b, // Channel B output word
  output logic data_valid, // Output words valid
  output logic fast_overrange_flag_a, // Channel A fast over-range
  output logic fast_overrange_flag_b, // Channel B fast over-range
  output logic sleep_active // Asleep or waking
);
  import amtoc_pkg::*;

  logic [15:0] cfg1;
  logic [15:0] corr_ctrl [NCH];
  amtoc_sleep_e sleep_cfg;
  amtoc_sleep_e sleep_mode;
  logic [3:0] overrange_threshold_field;
  logic [15:0] tp_ctrl_a;
  logic [15:0] tp_word;
  logic [15:0] tp_ctrl_b;
  amtoc_pwr_e state;
  amtoc_pwr_e next_state;
  logic [15:0] wake_cnt;
  logic [15:0] next_wake_cnt;
  logic phase;
  logic [15:0] next_rdata;

  wire wr_cfg1 = reg_wr_en && (reg_addr == ADDR_CFG1);
  wire wr_corr_a = reg_wr_en && (reg_addr == ADDR_CORR_A);
  wire wr_corr_b = reg_wr_en && (reg_addr == ADDR_CORR_B);
  wire wr_sleep = reg_wr_en && (reg_addr == ADDR_SLEEP);
  wire wr_thr = reg_wr_en && (reg_addr == ADDR_OVR_THR);
  wire wr_tpa = reg_wr_en && (reg_addr == ADDR_TP_CTRL_A);
  wire wr_tpw = reg_wr_en && (reg_addr == ADDR_TP_WORD);
  wire wr_tpb = reg_wr_en && (reg_addr == ADDR_TP_CTRL_B);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cfg1 <= CFG1_RST;
      corr_ctrl[0] <= CORR_RST;
      corr_ctrl[1] <= CORR_RST;
      sleep_cfg <= amtoc_sleep_e'(SLEEP_RST);
      overrange_threshold_field <= OVR_THR_RST;
      tp_ctrl_a <= TP_RST;
      tp_word <= TP_RST;
      tp_ctrl_b <= TP_RST;
    end else begin
      if (wr_cfg1) cfg1 <= reg_wdata;
      if (wr_corr_a) corr_ctrl[0] <= reg_wdata;
      if (wr_corr_b) corr_ctrl[1] <= reg_wdata;
      if (wr_sleep) sleep_cfg <= amtoc_sleep_e'(reg_wdata[1:0]);
      if (wr_thr) overrange_threshold_field <= reg_wdata[3:0];
      if (wr_tpa) tp_ctrl_a <= reg_wdata;
      if (wr_tpw) tp_word <= reg_wdata;
      if (wr_tpb) tp_ctrl_b <= reg_wdata;
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_addr == ADDR_CFG1) begin
      next_rdata = cfg1;
    end else if (reg_addr == ADDR_CORR_A) begin
      next_rdata = corr_ctrl[0];
    end else if (reg_addr == ADDR_CORR_B) begin
      next_rdata = corr_ctrl[1];
    end else if (reg_addr == ADDR_SLEEP) begin
      next_rdata = {(state != PWR_RUN), 13'h0000, sleep_cfg};
    end else if (reg_addr == ADDR_OVR_THR) begin
      next_rdata = {12'h000, overrange_threshold_field};
    end else if (reg_addr == ADDR_TP_CTRL_A) begin
      next_rdata = tp_ctrl_a;
    end else if (reg_addr == ADDR_TP_WORD) begin
      next_rdata = tp_word;
    end else if (reg_addr == ADDR_TP_CTRL_B) begin
      next_rdata = tp_ctrl_b;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) reg_rdata <= 16'h0000;
    else if (reg_rd_en) reg_rdata <= next_rdata;
  end

  // Power state: mode is frozen at sleep entry so a late config write cannot shorten the wake wait
  wire [15:0] wake_len = (sleep_mode == SLP_SHUTDOWN) ? 16'(WAKE_SHUTDOWN) :
                         (sleep_mode == SLP_STANDBY) ? 16'(WAKE_STANDBY_CYC) :
                         (sleep_mode == SLP_DEEP) ? 16'(WAKE_DEEP_CYC) : 16'(WAKE_LIGHT_CYC);

  always_comb begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    case (state)
      PWR_RUN: begin
        if (!enable_pin) next_state = PWR_SLEEP;
      end
      PWR_SLEEP: begin
        if (enable_pin) begin
          next_state = PWR_WAKE;
          next_wake_cnt = wake_len;
        end
      end
      PWR_WAKE: begin
        next_wake_cnt = wake_cnt - 16'h0001;
        if (!enable_pin) next_state = PWR_SLEEP;
        else if (wake_cnt == 16'h0001) next_state = PWR_RUN;
      end
      default: next_state = PWR_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= PWR_RUN;
      wake_cnt <= 16'h0000;
      sleep_mode <= amtoc_sleep_e'(SLEEP_RST);
      sleep_active <= 1'b0;
    end else begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
      if (state == PWR_RUN && next_state == PWR_SLEEP) sleep_mode <= sleep_cfg;
      sleep_active <= (next_state != PWR_RUN);
    end
  end

  // Test pattern decode; anything in range but off the preset table is taken as custom
  wire tp_on = tp_ctrl_a[15] && !tp_ctrl_a[14];
  wire [2:0] tp_kind_w =
    !tp_on ? TP_OFF :
    (tp_ctrl_a == TP_ZERO_A && tp_word == TP_ZERO_W && tp_ctrl_b == TP_ZERO_B) ? TP_ZEROS :
    (tp_ctrl_a == TP_ONES_A && tp_word == TP_ONES_W && tp_ctrl_b == TP_ONES_B) ? TP_ONES :
    (tp_ctrl_a == TP_TAA_A && tp_word == TP_TAA_W && tp_ctrl_b == TP_TAA_B) ? TP_TOG_AA :
    (tp_ctrl_a == TP_TFF_A && tp_word == TP_TFF_W && tp_ctrl_b == TP_TFF_B) ? TP_TOG_FF : TP_CUSTOM;
  wire amtoc_tp_e tp_kind = amtoc_tp_e'(tp_kind_w);
  wire [11:0] tp_value = (tp_kind == TP_ZEROS) ? PAT_000 :
                         (tp_kind == TP_ONES) ? PAT_FFF :
                         (tp_kind == TP_TOG_AA) ? (phase ? PAT_555 : PAT_AAA) :
                         (tp_kind == TP_TOG_FF) ? (phase ? PAT_FFF : PAT_000) : tp_word[13:2];

  always_ff @(posedge clock) begin
    if (!rstn) phase <= 1'b0;
    else phase <= !phase;
  end

  wire [11:0] sub_even [NCH];
  wire [11:0] sub_odd [NCH];
  assign sub_even[0] = sub_even_a;
  assign sub_odd[0] = sub_odd_a;
  assign sub_even[1] = sub_even_b;
  assign sub_odd[1] = sub_odd_b;
  wire [12:0] thr_level = {2'b00, overrange_threshold_field, 7'h00};
  wire running = (state == PWR_RUN);
  logic [11:0] out_word [NCH];
  logic ovr_out [NCH];

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      logic signed [11:0] off_acc;
      logic [OVR_LATENCY-1:0] ovr_pipe;
      wire corr_en = (ch == 0) ? cfg1[CFG1_CORR_EN_A] : cfg1[CFG1_CORR_EN_B];
      wire restart = corr_ctrl[ch][CORR_RESTART];
      wire dc_en = corr_ctrl[ch][CORR_DC_EN];
      // Odd half is trimmed toward the even half; offset is wrap-around, no gain trim
      wire [11:0] odd_fix = sub_odd[ch] + (corr_en ? off_acc : 12'sh000);
      wire [11:0] raw = phase ? odd_fix : sub_even[ch];
      wire signed [11:0] diff = $signed(sub_even[ch]) - $signed(odd_fix);
      wire [12:0] ext = {raw[11], raw};
      wire [12:0] mag = raw[11] ? (13'h0000 - ext) : ext;
      wire hit = running && (mag > thr_level);
      always_ff @(posedge clock) begin
        if (!rstn || restart) off_acc <= 12'sh000;
        else if (corr_en && dc_en && phase && diff != 12'sh000) begin
          off_acc <= diff[11] ? off_acc - 12'sh001 : off_acc + 12'sh001;
        end
      end
      always_ff @(posedge clock) begin
        if (!rstn) begin
          ovr_pipe <= '0;
          out_word[ch] <= 12'h000;
        end else begin
          ovr_pipe <= {ovr_pipe[OVR_LATENCY-2:0], hit};
          out_word[ch] <= !running ? 12'h000 : (tp_kind != TP_OFF) ? tp_value : raw;
        end
      end
      assign ovr_out[ch] = ovr_pipe[OVR_LATENCY-1];
      a_ovr_latency: assert property (@(posedge clock) disable iff (!rstn)
        hit |-> ##12 ovr_out[ch]) else $error("over-range flag late or missing");
      a_restart_clear: assert property (@(posedge clock) disable iff (!rstn)
        restart |=> off_acc == 12'sh000) else $error("restart did not clear accumulator");
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rstn) data_valid <= 1'b0;
    else data_valid <= running;
  end
  assign data_a = out_word[0];
  assign data_b = out_word[1];
  assign fast_overrange_flag_a = ovr_out[0];
  assign fast_overrange_flag_b = ovr_out[1];

  logic [15:0] wait_cyc;
  always_ff @(posedge clock) begin
    if (!rstn || state != PWR_WAKE) wait_cyc <= 16'h0000;
    else wait_cyc <= wait_cyc + 16'h0001;
  end

  a_sleep_entry: assert property (@(posedge clock) disable iff (!rstn)
    (state == PWR_RUN && !enable_pin) |=> state == PWR_SLEEP ##1 !data_valid) else $error("no sleep on low enable");
  a_wake_length: assert property (@(posedge clock) disable iff (!rstn)
    (state == PWR_WAKE && next_state == PWR_RUN) |-> wait_cyc == wake_len - 16'h0001) else $error("wake wait wrong");
  a_invalid_asleep: assert property (@(posedge clock) disable iff (!rstn)
    state != PWR_RUN |=> !data_valid) else $error("data valid while asleep");
  a_mode_latched: assert property (@(posedge clock) disable iff (!rstn)
    (state == PWR_RUN && next_state == PWR_SLEEP) |=> sleep_mode == $past(sleep_cfg)) else $error("sleep mode not taken");
  a_thr_reset: assert property (@(posedge clock)
    !rstn |=> overrange_threshold_field == 4'hF && !cfg1[CFG1_CORR_EN_A] && !cfg1[CFG1_CORR_EN_B]) else $error("reset values wrong");
  a_ones_pattern: assert property (@(posedge clock) disable iff (!rstn)
    (running && tp_kind == TP_ONES) |=> data_a == 12'hFFF && data_b == 12'hFFF) else $error("ones pattern wrong");
  a_custom_word: assert property (@(posedge clock) disable iff (!rstn)
    (running && tp_kind == TP_CUSTOM) |=> data_a == $past(tp_word[13:2])) else $error("custom word wrong");
  a_toggle_alt: assert property (@(posedge clock) disable iff (!rstn)
    (running && tp_kind == TP_TOG_AA) ##1 (running && tp_kind == TP_TOG_AA) |=> data_a != $past(data_a))
    else $error("toggle pattern stuck");
  a_thr_readback: assert property (@(posedge clock) disable iff (!rstn)
    (reg_rd_en && reg_addr == ADDR_OVR_THR) |=> reg_rdata == {12'h000, $past(overrange_threshold_field)})
    else $error("threshold readback wrong");

  c_wake_done: cover property (@(posedge clock) disable iff (!rstn) state == PWR_WAKE ##1 state == PWR_RUN);
  c_overrange: cover property (@(posedge clock) disable iff (!rstn) fast_overrange_flag_a);
  c_pattern_ff: cover property (@(posedge clock) disable iff (!rstn) running && tp_kind == TP_TOG_FF);
endmodule
`default_nettype wire

// >>> tb/adc_mode_testpattern_overrange_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_mode_testpattern_overrange_ctrl_test;
  import amtoc_pkg::*;
  logic clock = 0, rstn = 0, enable_pin = 1, reg_wr_en = 0, reg_rd_en = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [11:0] val_a = 12'h000, val_b = 12'h000, skew = 12'h000;
  logic [11:0] ea, oa, eb, ob, data_a, data_b;
  logic data_valid, fast_overrange_flag_a, fast_overrange_flag_b, sleep_active;
  int n_fail = 0, n_checks = 0, n_cyc = 0;
  logic [15:0] tp [5][3] = '{'{16'h8000, 16'h0000, 16'h0000}, '{16'hBFFC, 16'h3FFC, 16'h3FFC},
    '{16'h9554, 16'h2AA8, 16'h1554}, '{16'hBFFC, 16'h0000, 16'h3FFC}, '{16'h8000, 16'h1234, 16'h0000}};
  logic [11:0] pv [5][2] = '{'{12'h000, 12'h000}, '{12'hFFF, 12'hFFF}, '{12'hAAA, 12'h555},
    '{12'hFFF, 12'h000}, '{12'h48D, 12'h48D}};
  int wk [4][2] = '{'{0, 20}, '{3, 50}, '{2, 500}, '{1, 2500}};

  amtoc_source src (.val_a(val_a), .val_b(val_b), .skew(skew), .even_a(ea), .odd_a(oa), .even_b(eb), .odd_b(ob));
  amtoc_ctrl #(.WAKE_SHUTDOWN(20)) uut (.clock(clock), .rstn(rstn), .enable_pin(enable_pin),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .sub_even_a(ea), .sub_odd_a(oa), .sub_even_b(eb), .sub_odd_b(ob), .reg_rdata(reg_rdata),
    .data_a(data_a), .data_b(data_b), .data_valid(data_valid), .fast_overrange_flag_a(fast_overrange_flag_a),
    .fast_overrange_flag_b(fast_overrange_flag_b), .sleep_active(sleep_active));

  initial begin
    forever #20 clock = ~clock;
  end

  task automatic end_sim;
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Ceiling sits well above the roughly 3400 cycles the sequence needs
  always @(posedge clock) begin
    n_cyc++;
    if (n_cyc == 12000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: register %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: data word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_wr_en = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr_en = 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clock);
    reg_rd_en = 1;
    reg_addr = a;
    @(negedge clock);
    reg_rd_en = 0;
    @(posedge clock);
    #1 chk_reg(reg_rdata, exp);
  endtask

  // Phase of the first sample is not pinned here, so either order is accepted
  task automatic chk_pair(input logic [11:0] a0, a1, b0, b1);
    logic [11:0] xa, xb;
    repeat (3) @(posedge clock);
    #1 xa = data_a;
    xb = data_b;
    @(posedge clock);
    #1 chk_word(data_a, (xa === a0) ? a1 : a0);
    chk_word(xa, (data_a === a1) ? a0 : a1);
    chk_word(data_b, (xb === b0) ? b1 : b0);
    chk_word(xb, (data_b === b1) ? b0 : b1);
  endtask

  initial begin
    repeat (6) @(negedge clock);
    rstn = 1;
    rd(ADDR_OVR_THR, 16'h000F);
    rd(ADDR_CFG1, 16'h0002);
    rd(ADDR_CORR_A, 16'h0000);
    rd(ADDR_CORR_B, 16'h0000);
    rd(ADDR_TP_CTRL_A, 16'h0000);
    rd(8'h50, 16'h0000);
    @(negedge clock);
    val_a = 12'h064;
    val_b = 12'h0C8;
    skew = 12'h001;
    chk_pair(12'h064, 12'h065, 12'h0C8, 12'h0C9);
    wr(ADDR_CFG1, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_TP_CTRL_A, tp[i][0]);
      wr(ADDR_TP_WORD, tp[i][1]);
      wr(ADDR_TP_CTRL_B, tp[i][2]);
      chk_pair(pv[i][0], pv[i][1], pv[i][0], pv[i][1]);
    end
    wr(ADDR_CFG1, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_TP_CTRL_A + 8'(i), 16'h0000);
    end
    chk_pair(12'h064, 12'h065, 12'h0C8, 12'h0C9);
    // Over-range at field 5: limit is 640, so a magnitude of 641 trips it and 640 does not
    wr(ADDR_OVR_THR, 16'h0005);
    rd(ADDR_OVR_THR, 16'h0005);
    @(negedge clock);
    skew = 12'h000;
    val_a = 12'h000;
    val_b = 12'h000;
    repeat (15) @(posedge clock);
    @(negedge clock);
    val_a = 12'h281;
    val_b = 12'hD80;
    // Flag is launched on the twelfth edge after the sample, so it is still low after eleven
    repeat (11) @(posedge clock);
    #1 chk_bit(fast_overrange_flag_a, 1'b0);
    @(posedge clock);
    #1 chk_bit(fast_overrange_flag_a, 1'b1);
    chk_bit(fast_overrange_flag_b, 1'b0);
    @(negedge clock);
    val_a = 12'h280;
    val_b = 12'hD7F;
    repeat (13) @(posedge clock);
    #1 chk_bit(fast_overrange_flag_a, 1'b0);
    chk_bit(fast_overrange_flag_b, 1'b1);
    @(negedge clock);
    // Correction on channel A only; B keeps its raw mismatch
    val_a = 12'h064;
    val_b = 12'h0C8;
    skew = 12'h00A;
    wr(ADDR_CFG1, 16'h8002);
    wr(ADDR_CORR_A, 16'h6000);
    chk_pair(12'h064, 12'h06E, 12'h0C8, 12'h0D2);
    wr(ADDR_CORR_A, 16'h2000);
    repeat (60) @(posedge clock);
    chk_pair(12'h064, 12'h064, 12'h0C8, 12'h0D2);
    rd(ADDR_CORR_A, 16'h2000);
    // Channel B now trimmed on its own control register
    wr(ADDR_CFG1, 16'h8202);
    wr(ADDR_CORR_B, 16'h2000);
    repeat (60) @(posedge clock);
    chk_pair(12'h064, 12'h064, 12'h0C8, 12'h0C8);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_SLEEP, 16'(wk[i][0]));
      @(negedge clock);
      enable_pin = 0;
      rd(ADDR_SLEEP, 16'h8000 | 16'(wk[i][0]));
      chk_bit(sleep_active, 1'b1);
      chk_word(data_a, 12'h000);
      @(negedge clock);
      enable_pin = 1;
      repeat (wk[i][1]) @(posedge clock);
      #1 chk_bit(sleep_active, 1'b1);
      @(posedge clock);
      #1 chk_bit(data_valid, 1'b0);
      chk_bit(sleep_active, 1'b0);
      @(posedge clock);
      #1 chk_bit(data_valid, 1'b1);
    end
    end_sim();
  end
endmodule
`default_nettype wire

// >>> tb/amtoc_source.sv
`timescale 1ns/1ps
`default_nettype none
module amtoc_source (
  input wire logic [amtoc_pkg::DATA_W-1:0] val_a, // Channel A input level
  input wire logic [amtoc_pkg::DATA_W-1:0] val_b, // Channel B input level
  input wire logic [amtoc_pkg::DATA_W-1:0] skew, // Odd-half mismatch
  output logic [amtoc_pkg::DATA_W-1:0] even_a, // Channel A even half
  output logic [amtoc_pkg::DATA_W-1:0] odd_a, // Channel A odd half
  output logic [amtoc_pkg::DATA_W-1:0] even_b, // Channel B even half
  output logic [amtoc_pkg::DATA_W-1:0] odd_b // Channel B odd half
);
  import amtoc_pkg::*;
  // Only the static offset mismatch between halves is modelled, not timing skew
  assign even_a = val_a;
  assign odd_a = val_a + skew;
  assign even_b = val_b;
  assign odd_b = val_b + skew;
endmodule
`default_nettype wire
